// File: hw/rsx_pkg.sv
// Purpose: shared constants and types of the rotate/skip execute unit
// Assumes: one instruction cycle per clk_i edge, 8-bit data path
// Notes: register map is word aligned, data in byte lane 0
`default_nettype none
package rsx_pkg;
  // ==========================================================
  // widths and sizes
  localparam int DATA_W = 8;
  localparam int MEM_AW = 4;
  localparam int MEM_DEPTH = 16;
  localparam int PC_W = 13;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] ADR_ACC = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_CTRL = 8'h08;
  localparam logic [7:0] ADR_STATE = 8'h0c;
  localparam logic [7:0] ADR_MEM_BASE = 8'h40;
  localparam logic [7:0] ADR_MEM_MASK = 8'hc3;
  // field positions
  localparam int CTRL_IRQ_EN_BIT = 0;
  localparam int STATE_DUMMY_BIT = 0;
  localparam int STATE_SKIP_BIT = 1;
  localparam int STATE_CNT_LSB = 8;
  // ==========================================================
  // values after reset
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic IRQ_EN_RST = 1'b0;
  localparam logic [7:0] MEM_RST = 8'h00;
  // instruction lengths in instruction cycles
  localparam int RET_CYCLES = 2;
  localparam int SKIP_CYCLES = 2;
  // ==========================================================
  // types
  typedef struct packed {
    logic overflow_flag;
    logic zero_flag;
    logic aux_carry_flag;
    logic carry_flag;
  } rsx_flags_t;
  typedef enum logic [4:0] {
    NOP_OP = 5'h00,
    OR_TO_MEMORY_OP = 5'h01,
    SUB_RETURN_OP = 5'h02,
    RETURN_VALUE_OP = 5'h03,
    INTERRUPT_RETURN_OP = 5'h04,
    ROTATE_LEFT_OP = 5'h05,
    ROTATE_LEFT_TO_ACC_OP = 5'h06,
    ROTATE_LEFT_CARRY_OP = 5'h07,
    ROTATE_LEFT_CARRY_TO_ACC_OP = 5'h08,
    ROTATE_RIGHT_OP = 5'h09,
    ROTATE_RIGHT_TO_ACC_OP = 5'h0a,
    ROTATE_RIGHT_CARRY_OP = 5'h0b,
    ROTATE_RIGHT_CARRY_TO_ACC_OP = 5'h0c,
    SUB_BORROW_OP = 5'h0d,
    SUB_BORROW_TO_MEMORY_OP = 5'h0e,
    DECREMENT_SKIP_ZERO_OP = 5'h0f,
    DECREMENT_SKIP_ZERO_TO_ACC_OP = 5'h10,
    INCREMENT_SKIP_ZERO_OP = 5'h11,
    INCREMENT_SKIP_ZERO_TO_ACC_OP = 5'h12,
    SKIP_BIT_NONZERO_OP = 5'h13,
    SKIP_BIT_CLEAR_OP = 5'h14,
    SET_BYTE_OP = 5'h15,
    SET_BIT_OP = 5'h16
  } rsx_op_t;
  typedef struct packed {
    rsx_op_t op;
    logic [3:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] imm;
  } rsx_instr_t;
  typedef enum logic {
    ST_RUN = 1'b0,
    ST_DUMMY = 1'b1
  } rsx_state_t;
endpackage
`default_nettype wire

// File: hw/rsx_exec.sv
// Purpose: execute stage for rotate, skip, return, set and borrow ops
// Assumes: fetch stage on clk_i, holds instr_i until instr_ready_o
// Notes: accumulator, flags, irq enable and data bytes on Wishbone
`default_nettype none
// Summary of operation
// - or-to-memory: byte gets acc or byte, only zero flag updated
// - plain return reloads pc from stack, two cycles, flags kept
// - return with value reloads pc and loads acc with immediate
// - interrupt return reloads pc and sets global irq enable
// - rotate left: byte shifts up, bit 7 into bit 0, flags kept
// - rotate left via carry: old carry to bit 0, bit 7 to carry
// - rotate right: byte shifts down, bit 0 into bit 7, flags kept
// - rotate right via carry: old carry to bit 7, bit 0 to carry
// - acc forms write acc only, byte kept, same flag effect
// - borrow subtract: acc + ~byte + carry into acc, four flags
// - memory borrow subtract: same sum and flags, into the byte
// - taken skip drops prefetched op, two cycles, else one
// - decrement-skip writes byte, skips on zero, flags kept
// - acc decrement-skip writes acc, byte kept, skips on zero
// - increment-skip writes byte, skips on wrap to zero
// - acc increment-skip writes acc, byte kept, skips on zero
// - skip when selected bit is one, no memory or flag change
// - set byte writes all ones, flags kept
// - set bit forces one selected bit, other seven kept
// - skip when selected bit is zero, one cycle otherwise
module rsx_exec
  import rsx_pkg::*;
(
  input wire logic clk_i, // instruction clock
  input wire logic rst_i, // sync reset, high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // bus write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // bus acknowledge
  input wire logic instr_valid_i, // instruction offered
  input wire rsx_instr_t instr_i, // decoded instruction
  input wire logic [PC_W-1:0] stack_top_i, // top of stack
  output logic instr_ready_o, // may take an op
  output logic pc_load_o, // reload pc, pulse
  output logic [PC_W-1:0] pc_value_o, // pc to load
  output logic skip_o, // drop prefetched op
  output logic [7:0] acc_o, // accumulator
  output rsx_flags_t flags_o, // status flags
  output logic irq_enable_o // global_irq_enable
);
  // ==========================================================
  // state
  logic [7:0] acc;
  rsx_flags_t flags;
  logic irq_en;
  logic [7:0] data_mem [MEM_DEPTH];
  rsx_state_t state;
  rsx_state_t next_state;
  logic ready;
  logic pc_load;
  logic [PC_W-1:0] pc_val;
  logic skip;
  logic last_skip;
  logic [7:0] exec_cnt;
  logic [31:0] rd_data;
  logic ack;

  // ==========================================================
  // operand fetch and datapath
  wire take = instr_valid_i && ready;
  wire rsx_op_t op = instr_i.op;
  wire [7:0] m = data_mem[instr_i.addr];
  wire c_in = flags.carry_flag;
  wire [7:0] rot_l = {m[6:0], m[7]};
  wire [7:0] rot_lc = {m[6:0], c_in};
  wire [7:0] rot_r = {m[0], m[7:1]};
  wire [7:0] rot_rc = {c_in, m[7:1]};
  wire [7:0] dec_v = m - 8'h01;
  wire [7:0] inc_v = m + 8'h01;
  wire [7:0] or_v = acc | m;
  wire [7:0] bit_mask = 8'h01 << instr_i.bit_sel;
  wire bit_v = m[instr_i.bit_sel];
  // borrow subtract as add of complement, carry is not-borrow
  wire [7:0] m_n = ~m;
  wire [8:0] sub_sum = {1'b0, acc} + {1'b0, m_n} + {8'h00, c_in};
  wire [4:0] sub_nib = {1'b0, acc[3:0]} + {1'b0, m_n[3:0]}
                     + {4'h0, c_in};
  wire sub_ovf = (acc[7] == m_n[7]) && (sub_sum[7] != acc[7]);
  wire sub_zero = (sub_sum[7:0] == 8'h00);

  // ==========================================================
  // decode: result, destination, flags, skip, return
  logic [7:0] res;
  logic wr_mem;
  logic wr_acc;
  rsx_flags_t next_flags;
  logic skip_hit;
  logic ret_hit;
  logic set_irq;
  always_comb begin
    res = m;
    wr_mem = 1'b0;
    wr_acc = 1'b0;
    next_flags = flags;
    skip_hit = 1'b0;
    ret_hit = 1'b0;
    set_irq = 1'b0;
    case (op)
      OR_TO_MEMORY_OP: begin
        res = or_v;
        wr_mem = 1'b1;
        next_flags.zero_flag = (or_v == 8'h00);
      end
      SUB_RETURN_OP: begin
        ret_hit = 1'b1;
      end
      RETURN_VALUE_OP: begin
        ret_hit = 1'b1;
        res = instr_i.imm;
        wr_acc = 1'b1;
      end
      INTERRUPT_RETURN_OP: begin
        ret_hit = 1'b1;
        set_irq = 1'b1;
      end
      ROTATE_LEFT_OP, ROTATE_LEFT_TO_ACC_OP: begin
        res = rot_l;
        wr_mem = (op == ROTATE_LEFT_OP);
        wr_acc = (op == ROTATE_LEFT_TO_ACC_OP);
      end
      ROTATE_LEFT_CARRY_OP, ROTATE_LEFT_CARRY_TO_ACC_OP: begin
        res = rot_lc;
        wr_mem = (op == ROTATE_LEFT_CARRY_OP);
        wr_acc = (op == ROTATE_LEFT_CARRY_TO_ACC_OP);
        next_flags.carry_flag = m[7];
      end
      ROTATE_RIGHT_OP, ROTATE_RIGHT_TO_ACC_OP: begin
        res = rot_r;
        wr_mem = (op == ROTATE_RIGHT_OP);
        wr_acc = (op == ROTATE_RIGHT_TO_ACC_OP);
      end
      ROTATE_RIGHT_CARRY_OP, ROTATE_RIGHT_CARRY_TO_ACC_OP: begin
        res = rot_rc;
        wr_mem = (op == ROTATE_RIGHT_CARRY_OP);
        wr_acc = (op == ROTATE_RIGHT_CARRY_TO_ACC_OP);
        next_flags.carry_flag = m[0];
      end
      SUB_BORROW_OP, SUB_BORROW_TO_MEMORY_OP: begin
        res = sub_sum[7:0];
        wr_acc = (op == SUB_BORROW_OP);
        wr_mem = (op == SUB_BORROW_TO_MEMORY_OP);
        next_flags.overflow_flag = sub_ovf;
        next_flags.zero_flag = sub_zero;
        next_flags.aux_carry_flag = sub_nib[4];
        next_flags.carry_flag = sub_sum[8];
      end
      DECREMENT_SKIP_ZERO_OP, DECREMENT_SKIP_ZERO_TO_ACC_OP: begin
        res = dec_v;
        wr_mem = (op == DECREMENT_SKIP_ZERO_OP);
        wr_acc = (op == DECREMENT_SKIP_ZERO_TO_ACC_OP);
        skip_hit = (dec_v == 8'h00);
      end
      INCREMENT_SKIP_ZERO_OP, INCREMENT_SKIP_ZERO_TO_ACC_OP: begin
        res = inc_v;
        wr_mem = (op == INCREMENT_SKIP_ZERO_OP);
        wr_acc = (op == INCREMENT_SKIP_ZERO_TO_ACC_OP);
        skip_hit = (inc_v == 8'h00);
      end
      SKIP_BIT_NONZERO_OP: begin
        skip_hit = bit_v;
      end
      SKIP_BIT_CLEAR_OP: begin
        skip_hit = !bit_v;
      end
      SET_BYTE_OP: begin
        res = 8'hff;
        wr_mem = 1'b1;
      end
      SET_BIT_OP: begin
        res = m | bit_mask;
        wr_mem = 1'b1;
      end
      default: begin
        res = m;
      end
    endcase
  end

  // ==========================================================
  // instruction sequencing: second cycle is a dummy slot
  always_comb begin
    case (state)
      ST_RUN: begin
        if (take && (skip_hit || ret_hit)) begin
          next_state = ST_DUMMY;
        end else begin
          next_state = ST_RUN;
        end
      end
      ST_DUMMY: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // ready and the pulses are registered so outputs stay clean
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_RUN;
      ready <= 1'b0;
      pc_load <= 1'b0;
      skip <= 1'b0;
    end else begin
      state <= next_state;
      ready <= (next_state == ST_RUN);
      pc_load <= take && ret_hit;
      skip <= take && skip_hit;
    end
  end

  // captured pc and bookkeeping for the state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_val <= '0;
      last_skip <= 1'b0;
      exec_cnt <= 8'h00;
    end else if (take) begin
      if (ret_hit) begin
        pc_val <= stack_top_i;
      end
      last_skip <= skip_hit;
      exec_cnt <= exec_cnt + 8'h01;
    end
  end

  // ==========================================================
  // bus decode; writes land at the edge that samples ack
  wire bus_req = wb_cyc_i && wb_stb_i;
  wire bus_wr = bus_req && wb_we_i && ack && wb_sel_i[0];
  // a taken instruction owns acc, flags and memory that cycle
  wire bus_wr_ok = bus_wr && !take;
  wire sel_acc = (wb_adr_i == ADR_ACC);
  wire sel_status = (wb_adr_i == ADR_STATUS);
  wire sel_ctrl = (wb_adr_i == ADR_CTRL);
  wire sel_state = (wb_adr_i == ADR_STATE);
  wire sel_mem = ((wb_adr_i & ADR_MEM_MASK) == ADR_MEM_BASE);
  wire [MEM_AW-1:0] mem_idx = wb_adr_i[MEM_AW+1:2];
  wire [31:0] state_word = {16'h0000, exec_cnt, 6'h00,
                            last_skip, (state == ST_DUMMY)};
  wire [31:0] rd_mux = sel_acc ? {24'h000000, acc} :
                       sel_status ? {28'h0000000, flags} :
                       sel_ctrl ? {31'h00000000, irq_en} :
                       sel_state ? state_word :
                       sel_mem ? {24'h000000, data_mem[mem_idx]} :
                       32'h00000000;

  // classic single cycle: ack one cycle after strobe, then drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rd_data <= 32'h00000000;
    end else begin
      ack <= bus_req && !ack;
      rd_data <= rd_mux;
    end
  end

  // ==========================================================
  // architectural registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc <= ACC_RST;
      flags <= FLAGS_RST;
    end else if (take) begin
      if (wr_acc) begin
        acc <= res;
      end
      flags <= next_flags;
    end else if (bus_wr_ok && sel_acc) begin
      acc <= wb_dat_i[7:0];
    end else if (bus_wr_ok && sel_status) begin
      flags <= wb_dat_i[3:0];
    end
  end

  // interrupt return set wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en <= IRQ_EN_RST;
    end else if (take && set_irq) begin
      irq_en <= 1'b1;
    end else if (bus_wr && sel_ctrl) begin
      irq_en <= wb_dat_i[CTRL_IRQ_EN_BIT];
    end
  end

  // data bytes, one write port shared by op and bus
  for (genvar g = 0; g < MEM_DEPTH; g++) begin : g_mem
    wire [MEM_AW-1:0] idx = MEM_AW'(g);
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        data_mem[g] <= MEM_RST;
      end else if (take && wr_mem && instr_i.addr == idx) begin
        data_mem[g] <= res;
      end else if (bus_wr_ok && sel_mem && mem_idx == idx) begin
        data_mem[g] <= wb_dat_i[7:0];
      end
    end
  end

  // ==========================================================
  // outputs
  assign wb_dat_o = rd_data;
  assign wb_ack_o = ack;
  assign instr_ready_o = ready;
  assign pc_load_o = pc_load;
  assign pc_value_o = pc_val;
  assign skip_o = skip;
  assign acc_o = acc;
  assign flags_o = flags;
  assign irq_enable_o = irq_en;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire acc_form = wr_acc && !ret_hit;
  wire flag_op = (op == OR_TO_MEMORY_OP) || (op == SUB_BORROW_OP)
    || (op == SUB_BORROW_TO_MEMORY_OP)
    || (op == ROTATE_LEFT_CARRY_OP) || (op == ROTATE_RIGHT_CARRY_OP)
    || (op == ROTATE_LEFT_CARRY_TO_ACC_OP)
    || (op == ROTATE_RIGHT_CARRY_TO_ACC_OP);

  chk_or_mem_result: assert property (
    take && op == OR_TO_MEMORY_OP |=>
    data_mem[$past(instr_i.addr)] == $past(or_v) &&
    flags.zero_flag == ($past(or_v) == 8'h00) &&
    flags[3] == $past(flags[3]) && flags[1:0] == $past(flags[1:0]))
    else $error("or to memory result or flags wrong");
  chk_ret_two_cycle: assert property (
    take && ret_hit |=> pc_load_o && !instr_ready_o &&
    pc_value_o == $past(stack_top_i) ##1 !pc_load_o && instr_ready_o)
    else $error("return did not reload pc over two cycles");
  chk_ret_value_acc: assert property (
    take && op == RETURN_VALUE_OP |=> acc_o == $past(instr_i.imm))
    else $error("return with value did not load acc");
  chk_interrupt_return_op_irq_on: assert property (
    take && op == INTERRUPT_RETURN_OP |=> irq_enable_o)
    else $error("interrupt return left irq enable clear");
  chk_rotate_carry_in: assert property (
    take && op == ROTATE_LEFT_CARRY_OP |=>
    data_mem[$past(instr_i.addr)] == {$past(m[6:0]), $past(c_in)} &&
    flags.carry_flag == $past(m[7]) && flags[3:1] == $past(flags[3:1]))
    else $error("left rotate through carry wrong");
  chk_rotate_right_c: assert property (
    take && op == ROTATE_RIGHT_CARRY_OP |=>
    data_mem[$past(instr_i.addr)] == {$past(c_in), $past(m[7:1])} &&
    flags.carry_flag == $past(m[0]))
    else $error("right rotate through carry wrong");
  chk_acc_form_keep: assert property (
    take && acc_form |=> acc_o == $past(res) &&
    data_mem[$past(instr_i.addr)] == $past(m))
    else $error("acc form touched memory or missed acc");
  chk_sub_borrow_acc: assert property (
    take && op == SUB_BORROW_OP |=> acc_o == $past(sub_sum[7:0]) &&
    flags.carry_flag == $past(sub_sum[8]) &&
    flags.aux_carry_flag == $past(sub_nib[4]))
    else $error("borrow subtract into acc wrong");
  chk_skip_two_cycle: assert property (
    take && skip_hit |=> skip_o && !instr_ready_o ##1
    !skip_o && instr_ready_o)
    else $error("taken skip did not insert one dummy cycle");
  chk_no_skip_one: assert property (
    take && !skip_hit && !ret_hit |=> !skip_o && instr_ready_o)
    else $error("untaken op did not finish in one cycle");
  chk_bit_skip_sel: assert property (
    take && (op == SKIP_BIT_NONZERO_OP) |=> skip_o == $past(bit_v))
    else $error("bit test skip disagrees with bit");
  chk_inc_wrap_skip: assert property (
    take && op == INCREMENT_SKIP_ZERO_OP |=>
    skip_o == ($past(m) == 8'hff) &&
    data_mem[$past(instr_i.addr)] == $past(inc_v))
    else $error("increment skip wrong");
  chk_flags_hold: assert property (
    take && !flag_op |=> flags_o == $past(flags))
    else $error("flags changed by an op that keeps them");

  cov_taken_skip: cover property (take && skip_hit);
  cov_interrupt_return_op: cover property (take && op == INTERRUPT_RETURN_OP);
  cov_sub_borrow: cover property (take && op == SUB_BORROW_OP
    && sub_ovf);
  cov_back_to_back: cover property (take ##1 take);
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Purpose: self-checking bench for the rotate/skip execute unit
// Assumes: registers are set over Wishbone while no op is offered
// Notes: expected values come from exp_of, never from design outputs
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); \
  end end
module tb_top
  import rsx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic instr_valid_i, instr_ready_o, pc_load_o, skip_o, irq_enable_o;
  rsx_instr_t instr_i;
  logic [PC_W-1:0] stack_top_i, pc_value_o;
  logic [7:0] acc_o;
  rsx_flags_t flags_o;
  int miscompares, num_checks, cycles;
  logic [31:0] seed;
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] mem;
    rsx_flags_t fl;
    logic skip;
    logic irq;
  } rsx_exp_t;
  rsx_exec DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .stack_top_i(stack_top_i),
    .instr_ready_o(instr_ready_o), .pc_load_o(pc_load_o),
    .pc_value_o(pc_value_o), .skip_o(skip_o), .acc_o(acc_o),
    .flags_o(flags_o), .irq_enable_o(irq_enable_o)
  );
  // ==========================================================
  // helpers
  // xorshift keeps the run repeatable from one fixed seed
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // reference result of one op, worked out from its semantics
  function automatic rsx_exp_t exp_of(input rsx_op_t op,
    input logic [7:0] a, input logic [7:0] m, input rsx_flags_t f,
    input logic [2:0] b, input logic [7:0] imm, input logic irq);
    rsx_exp_t e;
    logic [8:0] s;
    logic [4:0] h;
    e = '{acc: a, mem: m, fl: f, skip: 1'b0, irq: irq};
    s = {1'b0, a} + {1'b0, ~m} + 9'(f.carry_flag);
    h = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + 5'(f.carry_flag);
    case (op)
      OR_TO_MEMORY_OP: begin
        e.mem = a | m;
        e.fl.zero_flag = ((a | m) == 8'h00);
      end
      RETURN_VALUE_OP: e.acc = imm;
      INTERRUPT_RETURN_OP: e.irq = 1'b1;
      ROTATE_LEFT_OP: e.mem = {m[6:0], m[7]};
      ROTATE_LEFT_TO_ACC_OP: e.acc = {m[6:0], m[7]};
      ROTATE_LEFT_CARRY_OP: e.mem = {m[6:0], f.carry_flag};
      ROTATE_LEFT_CARRY_TO_ACC_OP: e.acc = {m[6:0], f.carry_flag};
      ROTATE_RIGHT_OP: e.mem = {m[0], m[7:1]};
      ROTATE_RIGHT_TO_ACC_OP: e.acc = {m[0], m[7:1]};
      ROTATE_RIGHT_CARRY_OP: e.mem = {f.carry_flag, m[7:1]};
      ROTATE_RIGHT_CARRY_TO_ACC_OP: e.acc = {f.carry_flag, m[7:1]};
      SUB_BORROW_OP: e.acc = s[7:0];
      SUB_BORROW_TO_MEMORY_OP: e.mem = s[7:0];
      DECREMENT_SKIP_ZERO_OP: e.mem = m - 8'h01;
      DECREMENT_SKIP_ZERO_TO_ACC_OP: e.acc = m - 8'h01;
      INCREMENT_SKIP_ZERO_OP: e.mem = m + 8'h01;
      INCREMENT_SKIP_ZERO_TO_ACC_OP: e.acc = m + 8'h01;
      SKIP_BIT_NONZERO_OP: e.skip = m[b];
      SKIP_BIT_CLEAR_OP: e.skip = !m[b];
      SET_BYTE_OP: e.mem = 8'hff;
      SET_BIT_OP: e.mem = m | (8'h01 << b);
      default: ;
    endcase
    // only the carry moves on the through-carry rotates
    if (op inside {ROTATE_LEFT_CARRY_OP, ROTATE_LEFT_CARRY_TO_ACC_OP})
      e.fl.carry_flag = m[7];
    if (op inside {ROTATE_RIGHT_CARRY_OP, ROTATE_RIGHT_CARRY_TO_ACC_OP})
      e.fl.carry_flag = m[0];
    if (op inside {SUB_BORROW_OP, SUB_BORROW_TO_MEMORY_OP})
      e.fl = '{(a[7] == ~m[7]) && (s[7] != a[7]), s[7:0] == 8'h00,
        h[4], s[8]};
    if (op inside {DECREMENT_SKIP_ZERO_OP, DECREMENT_SKIP_ZERO_TO_ACC_OP})
      e.skip = (m == 8'h01);
    if (op inside {INCREMENT_SKIP_ZERO_OP, INCREMENT_SKIP_ZERO_TO_ACC_OP})
      e.skip = (m == 8'hff);
    return e;
  endfunction
  // one classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] adr,
    input logic [7:0] dat, output logic [7:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h000000, dat};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  // offer an op, then a nop right behind it to time the next take
  task automatic run_op(input rsx_instr_t ins, input rsx_exp_t e,
    input logic ret, input logic [PC_W-1:0] stk);
    int n;
    @(posedge clk_i);
    stack_top_i <= stk;
    instr_valid_i <= 1'b1;
    instr_i <= ins;
    do @(posedge clk_i); while (instr_ready_o !== 1'b1);
    instr_i <= '{op: NOP_OP, default: '0};
    @(posedge clk_i);
    `CHK(acc_o, e.acc)
    `CHK(flags_o, e.fl)
    `CHK(irq_enable_o, e.irq)
    `CHK(skip_o, e.skip)
    `CHK(pc_load_o, ret)
    if (ret) `CHK(pc_value_o, stk)
    n = 1;
    while (instr_ready_o !== 1'b1 && n < 4) begin
      @(posedge clk_i);
      n++;
    end
    instr_valid_i <= 1'b0;
    `CHK(n, 1 + int'(e.skip | ret))
    if (n == 2) `CHK({skip_o, pc_load_o}, 2'b00)
  endtask
  // closing report, the only place the run ends
  task automatic end_sim();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // the full run needs about 4200 cycles; far above that is a hang
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      end_sim();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] r, r2;
    logic [7:0] rd, m, madr;
    rsx_op_t op;
    rsx_instr_t ins;
    rsx_exp_t e;
    logic ret;
    seed = 32'h0ebb;
    miscompares = 0;
    num_checks = 0;
    cycles = 0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, instr_valid_i} = 4'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h00000000;
    instr_i = '{op: NOP_OP, default: '0};
    stack_top_i = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, then an unmapped place that must stay empty
    wb(1'b1, 8'h20, 8'hff, rd);
    // acc, status, ctrl, state word, first data byte, unmapped place
    for (int j = 0; j < 6; j++) begin
      madr = (j < 4) ? 8'(j * 4) : 8'h20;
      if (j == 4) madr = ADR_MEM_BASE;
      wb(1'b0, madr, 8'h00, rd);
      `CHK(rd, 8'h00)
    end
    // every op code, first pass with byte 01 (ff for increment-skip), the rest random
    for (int k = 0; k <= 22; k++) begin
      for (int i = 0; i < 10; i++) begin
        r = rnd();
        r2 = rnd();
        op = rsx_op_t'(5'(k));
        m = r[15:8];
        if (i == 0) m = (op inside {INCREMENT_SKIP_ZERO_OP,
          INCREMENT_SKIP_ZERO_TO_ACC_OP}) ? 8'hff : 8'h01;
        ins = '{op: op, addr: r[23:20], bit_sel: r[26:24], imm: r2[7:0]};
        madr = ADR_MEM_BASE + {2'b00, ins.addr, 2'b00};
        ret = op inside {SUB_RETURN_OP, RETURN_VALUE_OP,
          INTERRUPT_RETURN_OP};
        wb(1'b1, ADR_ACC, r[7:0], rd);
        wb(1'b1, ADR_STATUS, {4'h0, r[19:16]}, rd);
        wb(1'b1, ADR_CTRL, {7'h00, r[27]}, rd);
        wb(1'b1, madr, m, rd);
        e = exp_of(op, r[7:0], m, rsx_flags_t'(r[19:16]), r[26:24],
          r2[7:0], r[27]);
        run_op(ins, e, ret, r2[20:8]);
        wb(1'b0, madr, 8'h00, rd);
        `CHK(rd, e.mem)
      end
    end
    end_sim();
  end
endmodule
`undef CHK
`default_nettype wire
